// [hdl/i2m_defines.svh]
/*
 * Register offsets, field positions and reset values of the I2C master sequencer.
 * Assumes it is included by bare name from the design module.
 */
`ifndef I2M_DEFINES_SVH
`define I2M_DEFINES_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define I2M_REG_CON2   2'h0
`define I2M_REG_BUF    2'h1
`define I2M_REG_RATE   2'h2
`define I2M_REG_STAT   2'h3

// ****************************************************************
// Second control register fields
// ****************************************************************
`define I2M_CON_START  0
`define I2M_CON_RSTART 1
`define I2M_CON_STOP   2
`define I2M_CON_RECV   3
`define I2M_CON_ACKSEQ 4
`define I2M_CON_ACKDT  5
`define I2M_CON_ACKST  6

// ****************************************************************
// Port status register fields
// ****************************************************************
`define I2M_ST_FULL    0
`define I2M_ST_OVER    1
`define I2M_ST_SIF     2
`define I2M_ST_START   3
`define I2M_ST_STOP    4
`define I2M_ST_BCOL    5
`define I2M_ST_WRITE_COLLISION_FLAG    6

// ****************************************************************
// Reset values
// ****************************************************************
`define I2M_RATE_RST   8'h18

`endif

// [hdl/i2m_pkg.sv]
/*
 * Types of the I2C master sequencer: sequence states, bit kinds, state record.
 * Assumes nothing of its surroundings.
 */
package i2m_pkg;

    // Sequencer states.
    typedef enum logic [4:0] {
        IDLE, ST_WAIT, ST_HOLD, RS_LOW, RS_SDA, RS_RISE, RS_HIGH, RS_HOLD,
        B_LOW, B_RISE, B_HIGH, SP_LOW, SP_RISE, SP_HIGH, SP_END
    } i2m_state_e;

    // Kind of bit train being clocked.
    typedef enum logic [1:0] {K_TX, K_RX, K_ACK} i2m_kind_e;

    // Whole state of the sequencer.
    typedef struct packed {
        i2m_state_e st;
        i2m_kind_e  kind;
        logic [6:0] bit_rate_counter;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic [7:0] buff;
        logic [7:0] add;
        logic [7:0] rdata;
        logic       start_enable_bit;
        logic       repeat_start_enable_bit;
        logic       stop_enable_bit;
        logic       rcen;
        logic       acken;
        logic       ackdt;
        logic       ackstat;
        logic       bf;
        logic       ov;
        logic       s;
        logic       p;
        logic       sif;
        logic       bcl;
        logic       write_collision_flag;
        logic       scl_oe;
        logic       sda_oe;
        logic       scl_m;
        logic       scl_s;
        logic       sda_m;
        logic       sda_s;
    } i2m_state_s;

endpackage

// [hdl/i2m_master.sv]
/*
 * I2C master sequencer: bit-rate counter, clock arbitration, Start, Repeated
 * Start, byte transmit and receive, acknowledge and Stop, with a register port.
 * Assumes ref_clk is twice the instruction rate, so each rising edge is one counter
 * tick, and that the pads resolve open-drain lines from the enables.
 */
`timescale 1ns/1ns
`include "i2m_defines.svh"

module i2m_master (
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [1:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe
);

    i2m_pkg::i2m_state_s r_q;
    i2m_pkg::i2m_state_s r_d;
    logic                tmo;
    logic                busy;
    logic                wl;

    // ****************************************************************
    // Helper functions
    // ****************************************************************

    // States in which the bit-rate counter runs.
    function automatic logic counting(input i2m_pkg::i2m_state_e st);
        counting = st inside {i2m_pkg::ST_WAIT, i2m_pkg::ST_HOLD, i2m_pkg::RS_SDA,
            i2m_pkg::RS_HIGH, i2m_pkg::RS_HOLD, i2m_pkg::B_LOW, i2m_pkg::B_HIGH,
            i2m_pkg::SP_LOW, i2m_pkg::SP_HIGH, i2m_pkg::SP_END};
    endfunction

    // Whether the current bit pulls SDA low.
    function automatic logic want_low(input i2m_pkg::i2m_kind_e k, input logic [3:0] n,
                                      input logic [7:0] sh, input logic ackdt);
        if (k == i2m_pkg::K_TX) begin
            want_low = (n < 4'h8) && !sh[7];
        end else if (k == i2m_pkg::K_ACK) begin
            want_low = !ackdt;
        end else begin
            want_low = 1'b0;
        end
    endfunction

    // Open drain: the lines are only ever pulled low.
    assign scl_out   = 1'b0;
    assign sda_out   = 1'b0;
    assign scl_oe    = r_q.scl_oe;
    assign sda_oe    = r_q.sda_oe;
    assign reg_rdata = r_q.rdata;

    // Counter timeout and busy status of the sequencer.
    assign tmo  = (r_q.bit_rate_counter == 7'h00);
    assign busy = (r_q.st != i2m_pkg::IDLE) || r_q.start_enable_bit || r_q.repeat_start_enable_bit || r_q.stop_enable_bit
                  || r_q.rcen || r_q.acken;
    assign wl   = want_low(r_q.kind, r_q.bitn, r_q.sh, r_q.ackdt);

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // Synchronisers, register port and sequencer in one pass.
    always_comb begin
        r_d       = r_q;
        r_d.scl_m = scl_in;
        r_d.scl_s = r_q.scl_m;
        r_d.sda_m = sda_in;
        r_d.sda_s = r_q.sda_m;
        // Counter runs down to zero and halts there.
        if (counting(r_q.st) && !tmo) begin
            r_d.bit_rate_counter = r_q.bit_rate_counter - 7'h01;
        end
        // Register writes.
        if (reg_wr) begin
            if (reg_addr == `I2M_REG_CON2) begin
                r_d.ackdt = reg_wdata[`I2M_CON_ACKDT];
                if (!busy) begin
                    r_d.start_enable_bit   = reg_wdata[`I2M_CON_START];
                    r_d.repeat_start_enable_bit  = reg_wdata[`I2M_CON_RSTART];
                    r_d.stop_enable_bit   = reg_wdata[`I2M_CON_STOP];
                    r_d.rcen  = reg_wdata[`I2M_CON_RECV];
                    r_d.acken = reg_wdata[`I2M_CON_ACKSEQ];
                end
            end else if (reg_addr == `I2M_REG_BUF) begin
                if (busy) begin
                    r_d.write_collision_flag = 1'b1;
                end else begin
                    r_d.buff = reg_wdata;
                    r_d.sh   = reg_wdata;
                    r_d.bf   = 1'b1;
                    r_d.kind = i2m_pkg::K_TX;
                    r_d.bitn = 4'h0;
                    r_d.bit_rate_counter  = r_q.add[6:0];
                    r_d.st   = i2m_pkg::B_LOW;
                end
            end else if (reg_addr == `I2M_REG_RATE) begin
                r_d.add = reg_wdata;
            end else begin
                // Write one to clear; hardware sets below win.
                if (reg_wdata[`I2M_ST_OVER]) r_d.ov = 1'b0;
                if (reg_wdata[`I2M_ST_SIF]) r_d.sif = 1'b0;
                if (reg_wdata[`I2M_ST_BCOL]) r_d.bcl = 1'b0;
                if (reg_wdata[`I2M_ST_WRITE_COLLISION_FLAG]) r_d.write_collision_flag = 1'b0;
            end
        end
        // Register reads; reading a received byte empties the buffer.
        if (reg_rd) begin
            if (reg_addr == `I2M_REG_CON2) begin
                r_d.rdata = {1'b0, r_q.ackstat, r_q.ackdt, r_q.acken, r_q.rcen,
                             r_q.stop_enable_bit, r_q.repeat_start_enable_bit, r_q.start_enable_bit};
            end else if (reg_addr == `I2M_REG_BUF) begin
                r_d.rdata = r_q.buff;
                if (r_q.kind == i2m_pkg::K_RX) r_d.bf = 1'b0;
            end else if (reg_addr == `I2M_REG_RATE) begin
                r_d.rdata = r_q.add;
            end else begin
                r_d.rdata = {1'b0, r_q.write_collision_flag, r_q.bcl, r_q.p, r_q.s, r_q.sif,
                             r_q.ov, r_q.bf};
            end
        end
        // Sequencer.
        case (r_q.st)
            i2m_pkg::IDLE: begin
                if (r_q.start_enable_bit) begin
                    if (r_q.scl_s && r_q.sda_s) begin
                        r_d.bit_rate_counter = r_q.add[6:0];
                        r_d.st  = i2m_pkg::ST_WAIT;
                    end else if (!r_q.scl_s && !r_q.sda_s) begin
                        r_d.bcl = 1'b1;
                        r_d.start_enable_bit = 1'b0;
                    end
                end else if (r_q.repeat_start_enable_bit) begin
                    r_d.scl_oe = 1'b1;
                    r_d.st     = i2m_pkg::RS_LOW;
                end else if (r_q.stop_enable_bit) begin
                    r_d.scl_oe = 1'b1;
                    r_d.bit_rate_counter    = r_q.add[6:0];
                    r_d.st     = i2m_pkg::SP_LOW;
                end else if (r_q.rcen || r_q.acken) begin
                    r_d.kind   = r_q.rcen ? i2m_pkg::K_RX : i2m_pkg::K_ACK;
                    r_d.bitn   = 4'h0;
                    r_d.scl_oe = 1'b1;
                    r_d.bit_rate_counter    = r_q.add[6:0];
                    r_d.st     = i2m_pkg::B_LOW;
                end
            end
            i2m_pkg::ST_WAIT: begin
                if (!r_q.scl_s) begin
                    r_d.bcl = 1'b1;
                    r_d.start_enable_bit = 1'b0;
                    r_d.st  = i2m_pkg::IDLE;
                end else if (tmo) begin
                    if (r_q.sda_s) begin
                        r_d.sda_oe = 1'b1;
                        r_d.s      = 1'b1;
                        r_d.p      = 1'b0;
                        r_d.bit_rate_counter    = r_q.add[6:0];
                        r_d.st     = i2m_pkg::ST_HOLD;
                    end else begin
                        r_d.bcl = 1'b1;
                        r_d.start_enable_bit = 1'b0;
                        r_d.st  = i2m_pkg::IDLE;
                    end
                end
            end
            i2m_pkg::ST_HOLD: begin
                if (tmo) begin
                    r_d.start_enable_bit = 1'b0;
                    r_d.sif = 1'b1;
                    r_d.st  = i2m_pkg::IDLE;
                end
            end
            i2m_pkg::RS_LOW: begin
                if (!r_q.scl_s) begin
                    r_d.bit_rate_counter    = {1'b0, r_q.add[5:0]};
                    r_d.sda_oe = 1'b0;
                    r_d.st     = i2m_pkg::RS_SDA;
                end
            end
            i2m_pkg::RS_SDA: begin
                if (tmo) begin
                    if (r_q.sda_s) begin
                        r_d.scl_oe = 1'b0;
                        r_d.st     = i2m_pkg::RS_RISE;
                    end else begin
                        r_d.bcl    = 1'b1;
                        r_d.repeat_start_enable_bit   = 1'b0;
                        r_d.scl_oe = 1'b0;
                        r_d.st     = i2m_pkg::IDLE;
                    end
                end
            end
            i2m_pkg::RS_RISE: begin
                if (r_q.scl_s) begin
                    if (!r_q.sda_s) begin
                        r_d.bcl  = 1'b1;
                        r_d.repeat_start_enable_bit = 1'b0;
                        r_d.st   = i2m_pkg::IDLE;
                    end else begin
                        r_d.bit_rate_counter = r_q.add[6:0];
                        r_d.st  = i2m_pkg::RS_HIGH;
                    end
                end
            end
            i2m_pkg::RS_HIGH: begin
                if (!r_q.scl_s) begin
                    r_d.bcl  = 1'b1;
                    r_d.repeat_start_enable_bit = 1'b0;
                    r_d.st   = i2m_pkg::IDLE;
                end else if (tmo) begin
                    r_d.sda_oe = 1'b1;
                    r_d.s      = 1'b1;
                    r_d.p      = 1'b0;
                    r_d.bit_rate_counter    = r_q.add[6:0];
                    r_d.st     = i2m_pkg::RS_HOLD;
                end
            end
            i2m_pkg::RS_HOLD: begin
                if (tmo) begin
                    r_d.repeat_start_enable_bit = 1'b0;
                    r_d.sif  = 1'b1;
                    r_d.st   = i2m_pkg::IDLE;
                end
            end
            i2m_pkg::B_LOW: begin
                r_d.scl_oe = 1'b1;
                if (!r_q.scl_s) r_d.sda_oe = wl;
                if (tmo) begin
                    r_d.scl_oe = 1'b0;
                    r_d.st     = i2m_pkg::B_RISE;
                end
            end
            i2m_pkg::B_RISE: begin
                if (r_q.scl_s) begin
                    r_d.bit_rate_counter = r_q.add[6:0];
                    r_d.st  = i2m_pkg::B_HIGH;
                end
            end
            i2m_pkg::B_HIGH: begin
                if (tmo) begin
                    r_d.scl_oe = 1'b1;
                    r_d.sh     = {r_q.sh[6:0], r_q.sda_s};
                    r_d.bitn   = r_q.bitn + 4'h1;
                    r_d.bit_rate_counter    = r_q.add[6:0];
                    r_d.st     = i2m_pkg::B_LOW;
                    if (r_q.kind == i2m_pkg::K_TX && r_q.bitn == 4'h7) r_d.bf = 1'b0;
                    if (r_q.kind != i2m_pkg::K_RX && !wl && !r_q.sda_s
                        && !(r_q.kind == i2m_pkg::K_TX && r_q.bitn == 4'h8)) begin
                        // Lost arbitration: let go of both lines.
                        r_d.bcl    = 1'b1;
                        r_d.scl_oe = 1'b0;
                        r_d.sda_oe = 1'b0;
                        r_d.acken  = 1'b0;
                        r_d.st     = i2m_pkg::IDLE;
                    end else if (r_q.kind == i2m_pkg::K_TX && r_q.bitn == 4'h8) begin
                        r_d.ackstat = r_q.sda_s;
                        r_d.sif     = 1'b1;
                        r_d.st      = i2m_pkg::IDLE;
                    end else if (r_q.kind == i2m_pkg::K_RX && r_q.bitn == 4'h7) begin
                        r_d.buff = {r_q.sh[6:0], r_q.sda_s};
                        r_d.ov   = r_q.ov | r_q.bf;
                        r_d.bf   = 1'b1;
                        r_d.rcen = 1'b0;
                        r_d.sif  = 1'b1;
                        r_d.st   = i2m_pkg::IDLE;
                    end else if (r_q.kind == i2m_pkg::K_ACK) begin
                        r_d.acken = 1'b0;
                        r_d.sif   = 1'b1;
                        r_d.st    = i2m_pkg::IDLE;
                    end
                end
            end
            i2m_pkg::SP_LOW: begin
                r_d.scl_oe = 1'b1;
                if (!r_q.scl_s) r_d.sda_oe = 1'b1;
                if (tmo) begin
                    r_d.scl_oe = 1'b0;
                    r_d.st     = i2m_pkg::SP_RISE;
                end
            end
            i2m_pkg::SP_RISE: begin
                if (r_q.scl_s) begin
                    r_d.bit_rate_counter = r_q.add[6:0];
                    r_d.st  = i2m_pkg::SP_HIGH;
                end
            end
            i2m_pkg::SP_HIGH: begin
                if (tmo) begin
                    r_d.sda_oe = 1'b0;
                    r_d.bit_rate_counter    = r_q.add[6:0];
                    r_d.st     = i2m_pkg::SP_END;
                end
            end
            i2m_pkg::SP_END: begin
                if (r_q.scl_s && r_q.sda_s) begin
                    r_d.p = 1'b1;
                    r_d.s = 1'b0;
                end
                if (tmo) begin
                    r_d.stop_enable_bit = 1'b0;
                    r_d.sif = 1'b1;
                    r_d.st  = i2m_pkg::IDLE;
                end
            end
            default: begin
                r_d.st = i2m_pkg::IDLE;
            end
        endcase
    end

    // ****************************************************************
    // State register
    // ****************************************************************

    // All state is cleared to an idle, released bus, except the rate register, which loads 8'h18, and the four line synchronisers, which load 1.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q       <= '0;
            r_q.st    <= i2m_pkg::IDLE;
            r_q.add   <= `I2M_RATE_RST;
            r_q.scl_m <= 1'b1;
            r_q.scl_s <= 1'b1;
            r_q.sda_m <= 1'b1;
            r_q.sda_s <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_buf_starts_count: assert property (
        reg_wr && reg_addr == `I2M_REG_BUF && !busy
        |=> r_q.st == i2m_pkg::B_LOW && r_q.bit_rate_counter == $past(r_q.add[6:0]))
        else $error("Buffer write did not start the counter.");
    a_count_halts: assert property (
        r_q.st == i2m_pkg::IDLE && r_d.st == i2m_pkg::IDLE |=> $stable(r_q.bit_rate_counter))
        else $error("Counter moved while halted.");
    a_count_steps: assert property (
        r_q.st == i2m_pkg::B_LOW && r_q.bit_rate_counter > 7'h01 ##1 r_q.st == i2m_pkg::B_LOW
        |-> r_q.bit_rate_counter == $past(r_q.bit_rate_counter) - 7'h01)
        else $error("Counter did not decrement by one per tick.");
    a_rise_pause: assert property (
        r_q.st == i2m_pkg::B_RISE && !r_q.scl_s |=> r_q.st == i2m_pkg::B_RISE)
        else $error("Counter left the SCL wait early.");
    a_rise_reload: assert property (
        r_q.st == i2m_pkg::B_RISE && r_q.scl_s
        |=> r_q.st == i2m_pkg::B_HIGH && r_q.bit_rate_counter == r_q.add[6:0] && !scl_oe)
        else $error("High time not reloaded from rate.");
    a_start_collide: assert property (
        r_q.st == i2m_pkg::ST_WAIT && !r_q.scl_s
        |=> r_q.bcl && r_q.st == i2m_pkg::IDLE && !r_q.start_enable_bit)
        else $error("Start collision not flagged.");
    a_start_done: assert property (
        r_q.st == i2m_pkg::ST_HOLD && tmo
        |=> !r_q.start_enable_bit && sda_oe && r_q.sif && r_q.st == i2m_pkg::IDLE)
        else $error("Start did not finish correctly.");
    a_write_collision_flag_drop: assert property (
        reg_wr && reg_addr == `I2M_REG_BUF && busy |=> r_q.write_collision_flag && $stable(r_q.buff))
        else $error("Buffer write during sequence not refused.");
    a_con_locked: assert property (
        reg_wr && reg_addr == `I2M_REG_CON2 && !tmo
        && ((r_q.st == i2m_pkg::ST_WAIT && r_q.scl_s) || r_q.st == i2m_pkg::ST_HOLD)
        |=> $stable({r_q.acken, r_q.rcen, r_q.stop_enable_bit, r_q.repeat_start_enable_bit, r_q.start_enable_bit}))
        else $error("Control low bits changed while busy.");
    a_rs_load: assert property (
        r_q.st == i2m_pkg::RS_LOW && !r_q.scl_s
        |=> r_q.bit_rate_counter == {1'b0, $past(r_q.add[5:0])} && !sda_oe && scl_oe)
        else $error("Repeated Start low phase wrong.");
    a_rs_done: assert property (
        r_q.st == i2m_pkg::RS_HOLD && tmo |=> !r_q.repeat_start_enable_bit && sda_oe && r_q.sif)
        else $error("Repeated Start did not finish correctly.");
    a_ack_capture: assert property (
        r_q.st == i2m_pkg::B_HIGH && tmo && r_q.kind == i2m_pkg::K_TX && r_q.bitn == 4'h8
        |=> r_q.ackstat == $past(r_q.sda_s) && r_q.sif ##1 r_q.st == i2m_pkg::IDLE)
        else $error("Acknowledge not captured.");

endmodule

// [dv/i2m_slave_model.sv]
/* Behavioural I2C slave that acknowledges bytes and may stretch SCL.
   Assumes the bench resolves the pulled-up open-drain wires. */
`timescale 1ns/1ns
module i2m_slave_model (
    input  wire logic       ref_clk,
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic [3:0] stretch,
    input  wire logic       nack,
    output logic            scl_low,
    output logic            sda_low,
    output logic      [7:0] rx_byte
);
    int bitc = 0;
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        rx_byte = 8'h00;
    end
    // A falling SDA while SCL is high restarts the bit count.
    always @(negedge sda) if (scl) bitc = 0;
    // Data bits are taken on rising SCL, most significant first.
    always @(posedge scl) begin
        if (bitc < 8) rx_byte = {rx_byte[6:0], sda};
        bitc = bitc + 1;
    end
    // Acknowledge after the eighth fall, release after the ninth, stretch SCL low.
    always @(negedge scl) begin
        if (bitc == 8) sda_low = !nack;
        if (bitc == 9) begin
            sda_low = 1'b0;
            bitc = 0;
        end
        scl_low = (stretch != 4'h0);
        repeat (stretch) @(posedge ref_clk);
        scl_low = 1'b0;
    end
endmodule

// [dv/tb_i2m_master.sv]
/* Self-checking bench of the I2C master sequencer with a slave model.
   Assumes the design carries its own assertions. */
`timescale 1ns/1ns
module tb_i2m_master;
    logic        ref_clk, rst_n, reg_wr, reg_rd, scl_oe, sda_oe, bus_low, nack;
    logic [1:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, rx_byte, v, b;
    logic [3:0]  stretch;
    logic [16:0] seed;
    wire         scl_w, sda_w, s_scl, s_sda, scl_o, sda_o;
    int          n_mismatch, samples_checked, hi_run, hi_min, t;

    // Open-drain wires are low while any party pulls them.
    assign scl_w = !(scl_oe | s_scl | bus_low);
    assign sda_w = !(sda_oe | s_sda | bus_low);

    i2m_master dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .scl_in(scl_w), .scl_out(scl_o), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe));
    i2m_slave_model slv_u (.ref_clk(ref_clk), .scl(scl_w), .sda(sda_w), .stretch(stretch),
        .nack(nack), .scl_low(s_scl), .sda_low(s_sda), .rx_byte(rx_byte));

    // Clock of 50 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Tracks the shortest SCL high run that ends in a fall.
    always @(posedge ref_clk) begin
        if (scl_w) hi_run <= hi_run + 1;
        else begin
            if (hi_run > 0 && hi_run < hi_min) hi_min <= hi_run;
            hi_run <= 0;
        end
    end
    function automatic int period(logic [7:0] rate);
        return rate[6:0] + 1;
    endfunction
    function automatic logic [16:0] lfsr(logic [16:0] s);
        return {s[15:0], s[16] ^ s[13]};
    endfunction
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [1:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // Polls status until done or collision, keeps it in v, then clears the flags.
    task automatic wait_sif();
        for (int i = 0; i < 3000; i++) begin
            rd(2'h3, v);
            if ((v & 8'h24) != 8'h00) break;
        end
        // A poll that runs out counts as a mismatch.
        if ((v & 8'h24) == 8'h00) n_mismatch++;
        wr(2'h3, 8'h66);
    endtask
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog far beyond the expected run length.
    initial begin
        #3000000;
        n_mismatch++;
        end_of_test();
    end
    // Main sequence: three transfers at random rates, then a collision.
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, bus_low, nack, stretch} = '0;
        {hi_run, n_mismatch, samples_checked} = '0;
        seed = 17'd87163;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(2'h2, v);
        check("rate reset", v, 8'h18);
        check("open drain", {6'h0, scl_o, sda_o}, 8'h00);
        for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            b = {4'h8, seed[3:0] | 4'h2};
            t = period(b);
            stretch <= 4'(k * 3);
            wr(2'h2, b);
            wr(2'h0, 8'h01);
            wr(2'h1, 8'hA5);
            wr(2'h0, 8'h03);
            wait_sif();
            check("start and write_collision_flag", v & 8'h48, 8'h48);
            rd(2'h0, v);
            check("start bits", v & 8'h1F, 8'h00);
            hi_min = 999;
            seed = lfsr(seed);
            b = {seed[10:4], k[0]};
            nack <= (k == 2);
            wr(2'h1, b);
            wait_sif();
            check("slave byte", rx_byte, b);
            rd(2'h0, v);
            check("ack status", {7'h0, v[6]}, {7'h0, k == 2});
            check("high floor", 8'(hi_min >= t), 8'h01);
            check("high ceiling", 8'(hi_min <= t + 5), 8'h01);
            check("scl kept low", {7'h0, scl_w}, 8'h00);
            // Receive a byte from an idle slave, then send an acknowledge.
            wr(2'h0, 8'h08);
            wait_sif();
            rd(2'h1, v);
            check("receive", v, 8'hFF);
            wr(2'h0, 8'h10);
            wait_sif();
            check("ack sent", v & 8'h20, 8'h00);
            wr(2'h0, 8'h02);
            wait_sif();
            check("repeat start", {6'h0, v[3], sda_oe}, 8'h03);
            wr(2'h0, 8'h04);
            wait_sif();
            check("stop", {5'h0, v[4], scl_oe, sda_oe}, 8'h04);
        end
        bus_low <= 1'b1;
        repeat (4) @(posedge ref_clk);
        wr(2'h0, 8'h01);
        wait_sif();
        check("collision", v & 8'h20, 8'h20);
        rd(2'h0, v);
        check("start dropped", v & 8'h01, 8'h00);
        end_of_test();
    end
endmodule
